// ---- common/acr_defs.svh ----
// Register addresses, field positions and reset values for the converter control block
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ACR_ADDR_CONFIG     8'hbc
`define ACR_ADDR_RES_LOW    8'hbd
`define ACR_ADDR_RES_HIGH   8'hbe
`define ACR_ADDR_REF_CTRL   8'hd1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACR_CONFIG_RESET    8'hf8
`define ACR_RES_RESET       8'h00
`define ACR_REF_RESET       8'h00
`define ACR_DIV_ZERO        5'h00
`define ACR_RESULT_ZERO     10'h000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACR_CFG_DIV_HI      7
`define ACR_CFG_DIV_LO      3
`define ACR_CFG_JUST_BIT    2
`define ACR_REF_TEMP_BIT    2
`define ACR_REF_BIAS_BIT    1
`define ACR_REF_SEL_BIT     3
`define ACR_REF_IREF_BIT    0

`endif

// ---- common/acr_pkg.sv ----
// Types shared by the converter control block
package acr_pkg;
  typedef enum logic {
    ACR_JUST_RIGHT,
    ACR_JUST_LEFT
  } acr_justify_t;

  typedef struct packed {
    logic [4:0] div_cnt;
    logic       clk_level;
    logic       conv_tick;
  } acr_div_state_t;

  typedef struct packed {
    logic [4:0]   clk_div;
    acr_justify_t justify;
    logic [7:0]   res_low;
    logic [7:0]   res_high;
    logic         temp_en;
    logic         bias_en;
    logic         ref_sel;
    logic         iref_en;
    logic [7:0]   rd_data;
  } acr_state_t;
endpackage

// ---- src/acr_clock_divider.sv ----
// Conversion clock divider: core clock divided by field value plus one
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.svh"

module acr_clock_divider
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Divider setting
  input  wire logic [4:0] div_value,
  input  wire logic       run,
  // Conversion clock
  output logic            conv_clock,
  output logic            conv_tick
);

  acr_div_state_t s_q;
  acr_div_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.conv_tick = 1'b0;
    if (!run) begin
      s_d.div_cnt   = `ACR_DIV_ZERO;
      s_d.clk_level = 1'b0;
    end else if (s_q.div_cnt >= div_value) begin
      // One conversion clock period per div_value+1 core clocks
      s_d.div_cnt   = `ACR_DIV_ZERO;
      s_d.conv_tick = 1'b1;
      s_d.clk_level = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 5'h01;
      // Low for the second half of the period, approximate for odd counts
      if (s_d.div_cnt > (div_value >> 1)) begin
        s_d.clk_level = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign conv_clock = s_q.clk_level;
  assign conv_tick  = s_q.conv_tick;

endmodule
`default_nettype wire

// ---- src/acr_converter_control.sv ----
// Converter configuration, result formatting and reference enables
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.svh"

module acr_converter_control
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Special-function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic [7:0]      sfr_rdata,
  // Converter core
  input  wire logic       conv_enable,
  input  wire logic       result_valid,
  input  wire logic [9:0] result_data,
  output logic            conversion_clock,
  output logic            conversion_tick,
  // Other users of the bias circuits
  input  wire logic       osc_enable,
  input  wire logic       clk_mult_enable,
  // Reference and sensor controls
  output logic            ref_source_select,
  output logic            converter_bias_enable,
  output logic            reference_bias_enable,
  output logic            internal_ref_enable,
  output logic            temp_sensor_enable,
  output logic            temp_sensor_hiz,
  // Positive input mux
  input  wire logic       mux_sel_temp,
  output logic            mux_route_temp
);

  acr_state_t s_q;
  acr_state_t s_d;
  logic [9:0] res_formatted;

  // ----------------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------------
  always_comb begin
    res_formatted = `ACR_RESULT_ZERO;
    if (s_q.justify == ACR_JUST_LEFT) begin
      res_formatted = result_data;
    end else begin
      res_formatted = result_data;
    end
  end

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Result bytes latched whole, but nothing locks them, so separate low and high byte reads can mix two conversions
    if (result_valid) begin
      unique case (s_q.justify)
        ACR_JUST_RIGHT: begin
          s_d.res_low  = res_formatted[7:0];
          s_d.res_high = {6'h00, res_formatted[9:8]};
        end
        ACR_JUST_LEFT: begin
          s_d.res_low  = {res_formatted[1:0], 6'h00};
          s_d.res_high = res_formatted[9:2];
        end
      endcase
    end
    if (sfr_wr) begin
      unique case (sfr_addr)
        `ACR_ADDR_CONFIG: begin
          s_d.clk_div = sfr_wdata[`ACR_CFG_DIV_HI:`ACR_CFG_DIV_LO];
          s_d.justify = acr_justify_t'(sfr_wdata[`ACR_CFG_JUST_BIT]);
        end
        `ACR_ADDR_RES_LOW: begin
          s_d.res_low = sfr_wdata;
        end
        `ACR_ADDR_RES_HIGH: begin
          s_d.res_high = sfr_wdata;
        end
        `ACR_ADDR_REF_CTRL: begin
          s_d.temp_en = sfr_wdata[`ACR_REF_TEMP_BIT];
          s_d.bias_en = sfr_wdata[`ACR_REF_BIAS_BIT];
          s_d.ref_sel = sfr_wdata[`ACR_REF_SEL_BIT];
          s_d.iref_en = sfr_wdata[`ACR_REF_IREF_BIT];
        end
        default: begin
        end
      endcase
    end
    // Read data registered; unmapped addresses read zero
    s_d.rd_data = `ACR_RES_RESET;
    if (sfr_rd) begin
      unique case (sfr_addr)
        `ACR_ADDR_CONFIG: begin
          // Bits 1..0 unused, read zero
          s_d.rd_data = {s_q.clk_div, s_q.justify, 2'b00};
        end
        `ACR_ADDR_RES_LOW: begin
          s_d.rd_data = s_q.res_low;
        end
        `ACR_ADDR_RES_HIGH: begin
          s_d.rd_data = s_q.res_high;
        end
        `ACR_ADDR_REF_CTRL: begin
          s_d.rd_data = {4'h0, s_q.ref_sel, s_q.temp_en, s_q.bias_en, s_q.iref_en};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q.clk_div  <= 5'(`ACR_CONFIG_RESET >> `ACR_CFG_DIV_LO);
      s_q.justify  <= ACR_JUST_RIGHT;
      s_q.res_low  <= `ACR_RES_RESET;
      s_q.res_high <= `ACR_RES_RESET;
      s_q.temp_en  <= 1'b0;
      s_q.bias_en  <= 1'b0;
      s_q.ref_sel  <= 1'b0;
      s_q.iref_en  <= 1'b0;
      s_q.rd_data  <= `ACR_RES_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------------
  acr_clock_divider u_div (
    .clock      (clock),
    .rst        (rst),
    .div_value  (s_q.clk_div),
    .run        (conv_enable),
    .conv_clock (conversion_clock),
    .conv_tick  (conversion_tick)
  );

  // ----------------------------------------------------------------------
  // Reference and bias enables
  // ----------------------------------------------------------------------
  // Stored bit can only add to the forced enable, never remove it
  assign converter_bias_enable = s_q.bias_en | conv_enable | osc_enable;
  assign reference_bias_enable = s_q.iref_en | s_q.temp_en | clk_mult_enable;
  assign ref_source_select     = s_q.ref_sel;
  assign internal_ref_enable   = s_q.iref_en;
  assign temp_sensor_enable    = s_q.temp_en;
  assign temp_sensor_hiz       = ~s_q.temp_en;
  // Routed even when the sensor is off; such samples are meaningless
  assign mux_route_temp        = mux_sel_temp;
  assign sfr_rdata             = s_q.rd_data;

endmodule
`default_nettype wire

// ---- test/acr_cc_checker.sv ----
// Assertion checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acr_cc_checker (
  // Clock, reset and register port
  input wire logic       clock, rst, sfr_wr, sfr_rd,
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
  // Converter side
  input wire logic       conv_enable, result_valid, conversion_clock, conversion_tick,
  input wire logic [9:0] result_data,
  // Reference side
  input wire logic       osc_enable, clk_mult_enable, ref_source_select, converter_bias_enable,
  input wire logic       reference_bias_enable, internal_ref_enable, temp_sensor_enable,
  input wire logic       temp_sensor_hiz, mux_sel_temp, mux_route_temp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Shadow of config; tb never writes the result bytes, so the format flag is enough
  logic [4:0] div_q;
  logic       just_q;
  logic       left_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      div_q  <= 5'h1f;
      just_q <= 1'b0;
      left_q <= 1'b0;
    end else begin
      if (sfr_wr && sfr_addr == 8'hbc) begin
        div_q  <= sfr_wdata[7:3];
        just_q <= sfr_wdata[2];
      end
      if (result_valid) left_q <= just_q;
    end
  end
  sequence s_gap;
    !conversion_tick [*2] ##1 conversion_tick;
  endsequence
  a_tick_period: assert property (
    conversion_tick && div_q == 5'h02 |=> s_gap) else $error("tick spacing wrong");
  a_cfg_readback: assert property (
    sfr_rd && !sfr_wr && sfr_addr == 8'hbc |=> sfr_rdata == {$past(div_q), $past(just_q), 2'b00})
    else $error("config readback wrong");
  a_left_low: assert property (
    sfr_rd && sfr_addr == 8'hbd && left_q |=> sfr_rdata[5:0] == 6'h00) else $error("low byte");
  a_right_high: assert property (
    sfr_rd && sfr_addr == 8'hbe && !left_q |=> sfr_rdata[7:2] == 6'h00) else $error("high byte");
  a_bias_forced: assert property (
    conv_enable || osc_enable |-> converter_bias_enable) else $error("bias not forced");
  a_bias_manual: assert property (
    sfr_wr && sfr_addr == 8'hd1 && sfr_wdata[1] |=> converter_bias_enable) else $error("bias");
  a_refbias_auto: assert property (
    internal_ref_enable || temp_sensor_enable || clk_mult_enable |-> reference_bias_enable)
    else $error("reference bias off");
  a_ref_select: assert property (
    sfr_wr && sfr_addr == 8'hd1 |=> ref_source_select == $past(sfr_wdata[3]))
    else $error("reference select wrong");
  a_temp_hiz: assert property (
    temp_sensor_hiz == !temp_sensor_enable) else $error("sensor state wrong");
  a_mux_route: assert property (
    mux_route_temp == mux_sel_temp) else $error("mux route wrong");
endmodule
bind acr_converter_control acr_cc_checker i_chk (.clock(clock), .rst(rst), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .conv_enable(conv_enable), .result_valid(result_valid), .conversion_clock(conversion_clock),
  .conversion_tick(conversion_tick), .result_data(result_data), .osc_enable(osc_enable),
  .clk_mult_enable(clk_mult_enable), .ref_source_select(ref_source_select),
  .converter_bias_enable(converter_bias_enable), .reference_bias_enable(reference_bias_enable),
  .internal_ref_enable(internal_ref_enable), .temp_sensor_enable(temp_sensor_enable),
  .temp_sensor_hiz(temp_sensor_hiz), .mux_sel_temp(mux_sel_temp),
  .mux_route_temp(mux_route_temp));
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clock = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic       conv_enable = 1'b0, result_valid = 1'b0, osc_enable = 1'b0;
  logic       clk_mult_enable = 1'b0, mux_sel_temp = 1'b0;
  logic [9:0] result_data = 10'h000;
  logic       cclk, tick, rsel, cbias, rbias, iref, temp, hiz, route;
  int         num_errors = 0, tests_run = 0;
  wire logic [7:0] flags = {rsel, cbias, rbias, iref, temp, hiz, route, 1'b0};
  always #4 clock = ~clock;
  acr_converter_control i_dut (.clock(clock), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .conv_enable(conv_enable), .result_valid(result_valid), .result_data(result_data),
    .conversion_clock(cclk), .conversion_tick(tick), .osc_enable(osc_enable),
    .clk_mult_enable(clk_mult_enable), .ref_source_select(rsel),
    .converter_bias_enable(cbias), .reference_bias_enable(rbias),
    .internal_ref_enable(iref), .temp_sensor_enable(temp), .temp_sensor_hiz(hiz),
    .mux_sel_temp(mux_sel_temp), .mux_route_temp(route));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a; sfr_wdata <= d; sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    sfr_addr <= a; sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1 cmp8(sfr_rdata, e);
  endtask
  task automatic cap(input logic [9:0] r);
    @(posedge clock);
    result_data <= r; result_valid <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
  endtask
  // Flags sampled one edge after the inputs change
  task automatic io(input logic o, input logic m, input logic [7:0] e);
    @(posedge clock);
    osc_enable <= o; clk_mult_enable <= m; mux_sel_temp <= m;
    @(posedge clock);
    #1 cmp8(flags, e);
  endtask
  task automatic give_verdict;
    $display("tests %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    give_verdict;
  end
  initial begin
    logic [7:0] n;
    logic [7:0] h;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    chk(8'hbc, 8'hf8);
    chk(8'hbd, 8'h00);
    chk(8'h00, 8'h00);
    wr(8'hbc, 8'hff);
    chk(8'hbc, 8'hfc);
    $display("test registers done");
    wr(8'hd1, 8'h0f);
    chk(8'hd1, 8'h0f);
    io(1'b0, 1'b0, 8'hf8);
    wr(8'hd1, 8'h00);
    io(1'b1, 1'b1, 8'h66);
    io(1'b0, 1'b0, 8'h04);
    wr(8'hd1, 8'h04);
    io(1'b0, 1'b0, 8'h28);
    $display("test reference done");
    wr(8'hbc, 8'h10);
    cap(10'h2a5);
    chk(8'hbd, 8'ha5);
    chk(8'hbe, 8'h02);
    wr(8'hbc, 8'h14);
    cap(10'h3ff);
    chk(8'hbd, 8'hc0);
    chk(8'hbe, 8'hff);
    $display("test result done");
    @(posedge clock);
    conv_enable <= 1'b1;
    repeat (4) @(posedge clock);
    n = 8'h00;
    h = 8'h00;
    repeat (30) begin
      @(posedge clock);
      #1 if (tick === 1'b1) n++;
      if (cclk === 1'b1) h++;
    end
    cmp8(n, 8'h0a);
    cmp8(h, 8'h14);
    cmp8(flags, 8'h68);
    $display("test divider done");
    give_verdict;
  end
endmodule
`default_nettype wire
